/* src/spi_frame_port.v */
// sixteen-bit serial slave port with a small byte register space
// assumes a host master on sclk/cs/mosi pins, all sampled by sys_clk_i (10 MHz)
//
// Behaviour
// - every frame carries sixteen input bits clocked by host serial clock
// - transfers only while chip select is low; idle otherwise
// - received word is acted on only after chip select rises
// - serial output released to high impedance when chip select rises
// - input bit captured on each falling serial clock edge
// - output updated with next bit after each rising serial clock edge
// - no pass-through of received bits; no daisy chaining
// - bad clock count discards word and flags error in next frame
// - bits 6..0 address, bit 7 write, bits 15..8 data
// - frames ignored while restart mode is active
// - write shows old byte; new value visible on next access
`timescale 1ns/1ps
`include "spi_frame_consts.vh"
module spi_frame_port #(
  parameter FRAME_BITS = `FRAME_BITS
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_b_i,
  // serial pins
  input wire serial_clk_i,
  input wire chip_select_low_i,
  input wire serial_in_line_i,
  output reg serial_out_line_o,
  output reg serial_out_line_oe_o,
  // device state
  input wire restart_mode_i,
  // decoded frame to device logic
  output reg frame_valid_o,
  output reg frame_write_o,
  output reg [`ADDR_W-1:0] frame_addr_o,
  output reg [7:0] frame_data_o,
  output reg frame_error_o
);

  // ==========================================
  // pin synchronisers
  reg [1:0] sclk_sync_r;
  reg [1:0] cs_sync_r;
  reg [1:0] sdi_sync_r;
  reg sclk_d_r;
  reg cs_d_r;

  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sclk_sync_r <= 2'h0;
      cs_sync_r <= 2'h3;
      sdi_sync_r <= 2'h0;
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], serial_clk_i};
      cs_sync_r <= {cs_sync_r[0], chip_select_low_i};
      sdi_sync_r <= {sdi_sync_r[0], serial_in_line_i};
      sclk_d_r <= sclk_sync_r[1];
      cs_d_r <= cs_sync_r[1];
    end
  end

  wire sclk_s = sclk_sync_r[1];
  wire cs_s = cs_sync_r[1];
  wire sdi_s = sdi_sync_r[1];
  wire cs_fall = cs_d_r & ~cs_s;
  wire cs_rise = ~cs_d_r & cs_s;
  wire in_frame = ~cs_s & ~cs_d_r;
  wire sclk_fall = in_frame & sclk_d_r & ~sclk_s;
  wire sclk_rise = in_frame & ~sclk_d_r & sclk_s;

  // ==========================================
  // field decoding
  function [`ADDR_W-1:0] addr_field;
    input [FRAME_BITS-1:0] word;
    begin
      addr_field = word[`ADDR_MSB:`ADDR_LSB];
    end
  endfunction

  function [7:0] data_field;
    input [FRAME_BITS-1:0] word;
    begin
      data_field = word[`DATA_MSB:`DATA_LSB];
    end
  endfunction

  function write_field;
    input [FRAME_BITS-1:0] word;
    begin
      write_field = word[`RW_BIT];
    end
  endfunction

  // zero clocks or exactly one full word
  function count_legal;
    input [`CNT_W-1:0] cnt;
    input over;
    begin
      count_legal = !over && (cnt == {`CNT_W{1'b0}} || cnt == FRAME_BITS);
    end
  endfunction

  // ==========================================
  // register space
  reg [7:0] regs_r [0:`REG_COUNT-1];
  integer i;

  // ==========================================
  // frame state
  reg [FRAME_BITS-1:0] shift_in_r;
  reg [FRAME_BITS-1:0] shift_out_r;
  reg [`CNT_W-1:0] bit_cnt_r;
  reg cnt_over_r;
  reg err_pending_r;
  reg restart_seen_r;

  wire [`ADDR_W-1:0] rx_addr = addr_field(shift_in_r);
  wire [7:0] rx_data = data_field(shift_in_r);
  wire rx_write = write_field(shift_in_r);
  wire count_ok = count_legal(bit_cnt_r, cnt_over_r);
  // full word and no restart anywhere in the frame
  wire frame_accept = count_ok && (bit_cnt_r == FRAME_BITS) && !restart_seen_r && !restart_mode_i;
  // error flag held through the first bit cell
  wire err_flag = err_pending_r | restart_mode_i;
  // address bits sit at the top once all of them are in
  wire addr_done = sclk_fall && (bit_cnt_r == `ADDR_W);
  wire [`ADDR_W-1:0] early_addr = shift_in_r[FRAME_BITS-1:FRAME_BITS-`ADDR_W];

  // ==========================================
  // input shift register and bit counter
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      shift_in_r <= {FRAME_BITS{1'b0}};
      bit_cnt_r <= {`CNT_W{1'b0}};
      cnt_over_r <= 1'b0;
    end else if (cs_fall) begin
      shift_in_r <= {FRAME_BITS{1'b0}};
      bit_cnt_r <= {`CNT_W{1'b0}};
      cnt_over_r <= 1'b0;
    end else if (sclk_fall) begin
      shift_in_r <= {sdi_s, shift_in_r[FRAME_BITS-1:1]};
      if (bit_cnt_r == FRAME_BITS) begin
        cnt_over_r <= 1'b1;
      end else begin
        bit_cnt_r <= bit_cnt_r + 1'b1;
      end
    end
  end

  // ==========================================
  // error and restart tracking
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      err_pending_r <= 1'b0;
      restart_seen_r <= 1'b0;
    end else if (cs_rise) begin
      err_pending_r <= !count_ok || restart_seen_r || restart_mode_i;
      restart_seen_r <= 1'b0;
    end else if (restart_mode_i && !cs_s) begin
      restart_seen_r <= 1'b1;
    end
  end

  // ==========================================
  // serial output
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      shift_out_r <= {FRAME_BITS{1'b0}};
      serial_out_line_o <= 1'b0;
      serial_out_line_oe_o <= 1'b0;
    end else if (cs_fall) begin
      shift_out_r <= {{(FRAME_BITS-1){1'b0}}, err_flag};
      serial_out_line_o <= err_flag;
      serial_out_line_oe_o <= 1'b1;
    end else if (cs_rise) begin
      serial_out_line_oe_o <= 1'b0;
      serial_out_line_o <= 1'b0;
    end else begin
      if (addr_done) begin
        shift_out_r[`DATA_MSB:`DATA_LSB] <= regs_r[early_addr];
      end
      if (sclk_rise) begin
        serial_out_line_o <= shift_out_r[bit_cnt_r[3:0]] | restart_mode_i;
      end
    end
  end

  // ==========================================
  // decoded frame outputs
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      frame_valid_o <= 1'b0;
      frame_write_o <= 1'b0;
      frame_addr_o <= {`ADDR_W{1'b0}};
      frame_data_o <= 8'h00;
      frame_error_o <= 1'b0;
    end else begin
      frame_valid_o <= 1'b0;
      if (cs_rise) begin
        if (frame_accept) begin
          frame_valid_o <= 1'b1;
          frame_write_o <= rx_write;
          frame_addr_o <= rx_addr;
          frame_data_o <= rx_data;
          frame_error_o <= 1'b0;
        end else begin
          frame_error_o <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // register store
  // commit after frame
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      for (i = 0; i < `REG_COUNT; i = i + 1) begin
        regs_r[i] <= `REG_RESET;
      end
    end else if (cs_rise && frame_accept && rx_write) begin
      regs_r[rx_addr] <= rx_data;
    end
  end

endmodule

/* common/spi_frame_consts.vh */
// constants for the sixteen-bit serial slave port
// assumes inclusion by the port module only
`ifndef SPI_FRAME_CONSTS_VH
`define SPI_FRAME_CONSTS_VH
`define FRAME_BITS 16
`define CNT_W 5
`define ADDR_W 7
`define ADDR_LSB 0
`define ADDR_MSB 6
`define RW_BIT 7
`define DATA_LSB 8
`define DATA_MSB 15
`define REG_COUNT 128
`define ERR_BIT 0
`define REG_RESET 8'h00
`endif

/* tb/spi_frame_port_props.sv */
// checker for the serial frame port
// assumes it is bound onto spi_frame_port
`timescale 1ns/1ps
module spi_frame_port_props #(
  parameter FRAME_BITS = 16
) (
  input wire sys_clk_i, rst_b_i, serial_clk_i, chip_select_low_i, serial_in_line_i, restart_mode_i,
  input wire serial_out_line_o, serial_out_line_oe_o, frame_valid_o, frame_write_o, frame_error_o,
  input wire [6:0] frame_addr_o,
  input wire [7:0] frame_data_o
);
  // ==========
  // properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_valid_pulse: assert property (frame_valid_o |=> !frame_valid_o) else $error("valid too long");
  a_decode_late: assert property (frame_valid_o |-> chip_select_low_i && $past(chip_select_low_i, 3))
    else $error("decode before select end");
  a_fields_hold: assert property (!frame_valid_o && !$past(frame_valid_o) |->
    $stable({frame_write_o, frame_addr_o, frame_data_o})) else $error("fields moved");
  a_oe_release: assert property ($rose(chip_select_low_i) |-> ##[1:5] !serial_out_line_oe_o)
    else $error("out not released");
  a_oe_drive: assert property ($fell(chip_select_low_i) |-> ##[1:5] serial_out_line_oe_o)
    else $error("out not driven");
  a_idle_quiet: assert property (chip_select_low_i [*6] |-> !serial_out_line_oe_o) else $error("driven idle");
  a_out_hold: assert property ((serial_out_line_oe_o && !serial_clk_i) [*6] |-> $stable(serial_out_line_o))
    else $error("out moved without clock rise");
  a_ok_clears: assert property (frame_valid_o |-> ##[0:1] !frame_error_o) else $error("error kept");
  a_restart_drop: assert property (restart_mode_i [*8] |-> !frame_valid_o) else $error("frame in restart");
  c_write: cover property (frame_valid_o && frame_write_o);
  c_err: cover property ($rose(frame_error_o));
  c_restart: cover property (restart_mode_i && !chip_select_low_i);
endmodule
bind spi_frame_port spi_frame_port_props #(.FRAME_BITS(FRAME_BITS)) u_props (.*);

/* tb/spi_host_model.sv */
// host master model for the serial pins
// assumes the bench calls xfer and reads back the word
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk_o, cs_low_o, mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 0;
    cs_low_o = 1;
    mosi_o = 0;
  end
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    cs_low_o = 0;
    #700 r[0] = miso_i;
    #100;
    for (int k = 0; k < n; k++) begin
      sclk_o = 1;
      mosi_o = w[k % 16];
      #400 sclk_o = 0;
      #200 if (k < 16) r[k] = miso_i;
      #200;
    end
    cs_low_o = 1;
    mosi_o = ~mosi_o;
    #800;
  endtask
endmodule

/* tb/tb.sv */
// bench: byte store model against the serial frame port
// assumes host model and checker are compiled first
`timescale 1ns/1ps
module tb;
  logic sys_clk_i = 0, rst_b_i = 0, restart_mode_i = 0;
  wire sclk, csl, mosi, so, oe, fv, fw, fe;
  wire [6:0] fa;
  wire [7:0] fd;
  int error_cnt = 0, checked = 0, vcnt = 0;
  bit errp = 0;
  logic [7:0] mem [128];
  logic [31:0] seed = 43115;
  logic [15:0] w;
  int ns [6] = '{5, 0, 17, 16, 16, 16};
  bit rm [6] = '{0, 0, 0, 0, 1, 0};
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (fv === 1'b1) vcnt <= vcnt + 1;
  spi_frame_port dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .serial_clk_i(sclk), .chip_select_low_i(csl),
    .serial_in_line_i(mosi), .serial_out_line_o(so), .serial_out_line_oe_o(oe), .restart_mode_i(restart_mode_i),
    .frame_valid_o(fv), .frame_write_o(fw), .frame_addr_o(fa), .frame_data_o(fd), .frame_error_o(fe));
  spi_host_model host (.sclk_o(sclk), .cs_low_o(csl), .mosi_o(mosi), .miso_i(oe ? so : 1'bz));
  // ==========
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task check(input string nm, input logic [15:0] got, exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic run(input logic [15:0] x, input int n, input bit rs);
    logic [15:0] r, m;
    int v;
    bit bad, good;
    v = vcnt;
    m = (n >= 16) ? 16'hffff : (n ? 16'hffff >> (16 - n) : 16'h0001);
    bad = (n != 0 && n != 16) || rs;
    good = n == 16 && !rs;
    @(negedge sys_clk_i) restart_mode_i = rs;
    host.xfer(x, n, r);
    @(negedge sys_clk_i) restart_mode_i = 0;
    check("out", r & m, rs ? m : {mem[x[6:0]], 7'h00, errp} & m);
    errp = bad;
    check("valid", 16'(vcnt - v), {15'h0000, good});
    if (n != 0) check("err", {15'h0000, fe}, {15'h0000, bad});
    if (good) check("fields", {fd, fw, fa}, x);
    if (good && x[7]) mem[x[6:0]] = x[15:8];
  endtask
  task results;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========
  // sequence
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (2) @(negedge sys_clk_i);
    rst_b_i = 1;
    repeat (3) @(negedge sys_clk_i);
    for (int i = 0; i < 12; i++) begin
      w = rnd();
      run(w | 16'h0080, 16, 0);
      run(w & 16'hff7f, 16, 0);
    end
    for (int i = 0; i < 6; i++) run(rnd(), ns[i], rm[i]);
    results;
  end
  initial begin
    #2_000_000;
    error_cnt++;
    results;
  end
endmodule
